// ---- core/ptwio_defines.svh ----
// constants for the two-word host control/status interface
`ifndef PTWIO_DEFINES_SVH
`define PTWIO_DEFINES_SVH
`define PTWIO_CTL_SAVE 3
`define PTWIO_CTL_SERWR 4
`define PTWIO_CTL_ALMCLR 5
`define PTWIO_CTL_RNGCLR 6
`define PTWIO_PK_LSB 8
`define PTWIO_ST_BADDATA 3
`define PTWIO_ST_CONVERR 4
`define PTWIO_ST_ALARM 5
`define PTWIO_ST_RANGE 6
`define PTWIO_ST_ALIVE 7
`define PTWIO_CLK_HZ 40000000
`define PTWIO_ALIVE_HZ 1
`define PTWIO_HALF_CYCLES (`PTWIO_CLK_HZ / (2 * `PTWIO_ALIVE_HZ))
`define PTWIO_STATUS_RST 16'h0000
`endif

// ---- core/ptwio_pkg.sv ----
// types for the two-word host control/status interface
package ptwio_pkg;
	typedef struct packed {
		logic bad_data;
		logic good_data;
		logic conv_err;
		logic [7:0] alarm;
		logic [7:0] out_range;
		logic [7:0] open_sensor;
		logic [7:0] chan_en;
	} ptwio_events_t;
	typedef struct packed {
		logic save_cfg;
		logic serial_wr_en;
		logic alarm_clr;
		logic range_clr;
		logic [7:0] peak_clr;
	} ptwio_cmds_t;
endpackage

// ---- core/ptwio_io_words.sv ----
// two-word host control/status interface of the temperature input module
`timescale 1ns/100ps
`include "ptwio_defines.svh"
module ptwio_io_words #(
	parameter int HALF_CYCLES = `PTWIO_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic two_word_jumper,
	input wire logic [15:0] host_control_word,
	input wire ptwio_pkg::ptwio_events_t events,
	input wire logic [7:0] peak_clr_done,
	output logic [15:0] module_status_word,
	output ptwio_pkg::ptwio_cmds_t cmds,
	output logic [7:0] open_sensor_flags
);
	import ptwio_pkg::*;

	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// jumper is a pin: three stages, change accepted when stages 2,3 agree
	logic [2:0] jmp_q, jmp_d;
	logic mode_q, mode_d;
	logic [15:0] ctl_q, ctl_d;
	logic [15:0] st_q, st_d;
	ptwio_cmds_t cmd_q, cmd_d;
	logic [7:0] open_q, open_d;
	logic [31:0] div_q, div_d;
	logic save_prev_q, save_prev_d;

	always_comb begin
		jmp_d = {jmp_q[1:0], two_word_jumper};
		mode_d = mode_q;
		if (jmp_q[1] == jmp_q[2])
			mode_d = jmp_q[2];
		ctl_d = host_control_word;
		st_d = st_q;
		open_d = open_q;
		div_d = div_q + 32'h00000001;
		save_prev_d = ctl_q[`PTWIO_CTL_SAVE];
		cmd_d = '0;
		if (mode_q) begin
			// save fires once per rising edge of the request bit
			cmd_d.save_cfg = ctl_q[`PTWIO_CTL_SAVE] && !save_prev_q;
			cmd_d.serial_wr_en = ctl_q[`PTWIO_CTL_SERWR];
			cmd_d.alarm_clr = ctl_q[`PTWIO_CTL_ALMCLR];
			cmd_d.range_clr = ctl_q[`PTWIO_CTL_RNGCLR];
			cmd_d.peak_clr = ctl_q[15:`PTWIO_PK_LSB];
			// valid data outranks invalid when both arrive together
			if (events.good_data)
				st_d[`PTWIO_ST_BADDATA] = 1'b0;
			else if (events.bad_data)
				st_d[`PTWIO_ST_BADDATA] = 1'b1;
			if (events.conv_err)
				st_d[`PTWIO_ST_CONVERR] = 1'b1;
			// set beats clear in the same cycle
			if (ctl_q[`PTWIO_CTL_ALMCLR])
				st_d[`PTWIO_ST_ALARM] = 1'b0;
			if (|events.alarm)
				st_d[`PTWIO_ST_ALARM] = 1'b1;
			if (ctl_q[`PTWIO_CTL_RNGCLR]) begin
				st_d[`PTWIO_ST_RANGE] = 1'b0;
				open_d = 8'h00;
			end
			if (|events.out_range)
				st_d[`PTWIO_ST_RANGE] = 1'b1;
			open_d = open_d | (events.open_sensor & events.chan_en);
			// ack only once done, dropped with request
			st_d[15:8] = ctl_q[15:8] & (st_q[15:8] | peak_clr_done);
			if (div_q >= 32'(HALF_CYCLES - 1)) begin
				div_d = 32'h00000000;
				st_d[`PTWIO_ST_ALIVE] = !st_q[`PTWIO_ST_ALIVE];
			end
		end else begin
			div_d = 32'h00000000;
			st_d[`PTWIO_ST_ALIVE] = 1'b0;
		end
		st_d[2:0] = 3'h0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			jmp_q <= 3'h0;
			mode_q <= 1'b0;
			ctl_q <= 16'h0000;
			st_q <= `PTWIO_STATUS_RST;
			cmd_q <= '0;
			open_q <= 8'h00;
			div_q <= 32'h00000000;
			save_prev_q <= 1'b0;
		end else if (!rst_s2_q) begin
			jmp_q <= 3'h0;
			mode_q <= 1'b0;
			ctl_q <= 16'h0000;
			st_q <= `PTWIO_STATUS_RST;
			cmd_q <= '0;
			open_q <= 8'h00;
			div_q <= 32'h00000000;
			save_prev_q <= 1'b0;
		end else begin
			jmp_q <= jmp_d;
			mode_q <= mode_d;
			ctl_q <= ctl_d;
			st_q <= st_d;
			cmd_q <= cmd_d;
			open_q <= open_d;
			div_q <= div_d;
			save_prev_q <= save_prev_d;
		end
	end

	assign module_status_word = st_q;
	assign cmds = cmd_q;
	assign open_sensor_flags = open_q;

	// high-time counter only feeds the alive duty check
	logic [31:0] hi_cnt_q, hi_cnt_d;
	always_comb begin
		hi_cnt_d = 32'h00000000;
		if (st_q[`PTWIO_ST_ALIVE])
			hi_cnt_d = hi_cnt_q + 32'h00000001;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hi_cnt_q <= 32'h00000000;
		else if (!rst_s2_q)
			hi_cnt_q <= 32'h00000000;
		else
			hi_cnt_q <= hi_cnt_d;
	end

	chk_alarm_sticky: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && |events.alarm |=> st_q[`PTWIO_ST_ALARM])
		else $error("alarm status not set");
	chk_range_sticky: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && |events.out_range |=> st_q[`PTWIO_ST_RANGE])
		else $error("range status not set");
	chk_alarm_clear: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[5] && !(|events.alarm) |=> !st_q[5])
		else $error("alarm status not cleared");
	chk_bad_data: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && events.bad_data && !events.good_data |=> st_q[3])
		else $error("bad data flag not set");
	chk_good_data: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && events.good_data |=> !st_q[3])
		else $error("bad data flag not cleared");
	chk_ack_drop: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		!ctl_q[8] |=> !st_q[8])
		else $error("ack held without request");
	chk_save_pulse: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		cmd_q.save_cfg |=> !cmd_q.save_cfg)
		else $error("save pulse too long");
	chk_reserved_zero: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		st_q[2:0] == 3'h0)
		else $error("reserved status bits set");
	chk_serial_gate: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[4] |=> cmd_q.serial_wr_en)
		else $error("serial write not permitted");
	chk_serial_block: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		!ctl_q[4] |=> !cmd_q.serial_wr_en)
		else $error("serial write not blocked");
	chk_range_clear: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[6] && !(|events.out_range) |=> !st_q[6])
		else $error("range status not cleared");
	chk_open_clear: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[6] && !(|events.open_sensor)
		|=> open_q == 8'h00)
		else $error("open sensor flags not cleared");
	chk_open_set: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && events.open_sensor[0] && events.chan_en[0]
		|=> open_q[0])
		else $error("open sensor flag not set");
	chk_conv_set: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && events.conv_err |=> st_q[4])
		else $error("conversion error not set");
	chk_conv_hold: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		st_q[4] |=> st_q[4])
		else $error("conversion error lost");
	chk_alarm_hold: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		st_q[5] && !ctl_q[5] |=> st_q[5])
		else $error("alarm status dropped without clear");
	chk_range_hold: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		st_q[6] && !ctl_q[6] |=> st_q[6])
		else $error("range status dropped without clear");
	chk_peak_cmd: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q |=> cmd_q.peak_clr == $past(ctl_q[15:8]))
		else $error("peak reset request not passed on");
	chk_ack_done: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		!st_q[8] && !peak_clr_done[0] |=> !st_q[8])
		else $error("ack before reset done");
	chk_ack_follow: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[8] && peak_clr_done[0] |=> st_q[8])
		else $error("ack missing after reset done");
	chk_alive_gated: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		!mode_q |=> !st_q[7])
		else $error("alive bit set outside two-word mode");
	chk_alive_high: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		hi_cnt_q <= 32'(HALF_CYCLES))
		else $error("alive high time too long");
	chk_idle_cmds: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		!mode_q |=> cmd_q == '0)
		else $error("commands issued outside two-word mode");
	chk_save_edge: assert property (@(posedge clk)
		disable iff (!rst_s2_q)
		mode_q && ctl_q[3] && !save_prev_q |=> cmd_q.save_cfg)
		else $error("save request not issued");
endmodule

// ---- test/ptwio_peak_model.sv ----
// peak-hold logic model answering channel reset requests
`timescale 1ns/100ps
module ptwio_peak_model (
	input wire logic clk,
	input wire logic [7:0] peak_clr,
	output logic [7:0] peak_clr_done
);
	// done a cycle after the request, held while it stays high
	always_ff @(posedge clk) begin
		peak_clr_done <= peak_clr;
	end
endmodule

// ---- test/ptwio_io_words_test.sv ----
// self-checking bench for the two-word control/status interface
`timescale 1ns/100ps
module ptwio_io_words_test;
	import ptwio_pkg::*;
	logic clk = 0, rstn = 0, jmp = 1;
	logic [15:0] ctl = 16'h0000, st;
	ptwio_events_t ev = '0;
	ptwio_cmds_t cmds;
	logic [7:0] done, opn;
	int error_cnt = 0, compares = 0;
	ptwio_io_words #(.HALF_CYCLES(10)) ptwio_io_words_inst (.clk(clk),
		.rstn(rstn), .two_word_jumper(jmp), .host_control_word(ctl),
		.events(ev), .peak_clr_done(done), .module_status_word(st),
		.cmds(cmds), .open_sensor_flags(opn));
	ptwio_peak_model ptwio_peak_model_inst (.clk(clk),
		.peak_clr(cmds.peak_clr), .peak_clr_done(done));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task summarize;
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// events last one cycle, channel enables stay as given
	task pulse(input ptwio_events_t e);
		ptwio_events_t idle;
		idle = '0;
		idle.chan_en = e.chan_en;
		ev = e;
		step(1);
		ev = idle;
		step(3);
	endtask
	task t_alive;
		int n;
		for (n = 0; n < 40 && st[7] !== 1'b0; n++) step(1);
		for (n = 0; n < 40 && st[7] !== 1'b1; n++) step(1);
		for (n = 0; n < 40 && st[7] === 1'b1; n++) step(1);
		chk(16'(n), 16'h000A);
		for (n = 0; n < 40 && st[7] === 1'b0; n++) step(1);
		chk(16'(n), 16'h000A);
	endtask
	task t_peak;
		ctl = 16'h8100;
		step(3);
		chk(st & 16'hFF00, 16'h0000);
		step(2);
		chk(st & 16'hFF00, 16'h8100);
		chk(16'(cmds.peak_clr), 16'h0081);
		ctl = 16'h0000;
		step(3);
		chk(st & 16'hFF00, 16'h0000);
	endtask
	task t_flags;
		ptwio_events_t e;
		e = '0;
		e.alarm[2] = 1'b1;
		e.out_range[7] = 1'b1;
		e.open_sensor[4] = 1'b1;
		e.open_sensor[1] = 1'b1;
		e.chan_en = 8'hFD;
		e.bad_data = 1'b1;
		e.conv_err = 1'b1;
		pulse(e);
		chk(st & 16'h0078, 16'h0078);
		chk(16'(opn), 16'h0010);
		ctl = 16'h0020;
		step(4);
		chk(st & 16'h0078, 16'h0058);
		chk(16'(cmds), 16'h0200);
		ctl = 16'h0040;
		step(4);
		chk(st & 16'hFF7F, 16'h0018);
		chk(16'(opn), 16'h0000);
		chk(16'(cmds), 16'h0100);
		ctl = 16'h0000;
		e = '0;
		e.good_data = 1'b1;
		pulse(e);
		chk(st & 16'h0078, 16'h0010);
	endtask
	task t_misc;
		ctl = 16'h0097;
		step(4);
		chk({st[2:0], 12'h000, cmds.serial_wr_en}, 16'h0001);
		chk(16'(cmds), 16'h0400);
		ctl = 16'h0008;
		step(2);
		chk(16'(cmds.save_cfg), 16'h0001);
		chk(16'(cmds.serial_wr_en), 16'h0000);
		step(1);
		chk(16'(cmds.save_cfg), 16'h0000);
	endtask
	// sticky conversion error only leaves through reset
	task t_reset;
		ctl = 16'h0000;
		rstn = 1'b0;
		step(2);
		chk(st, 16'h0000);
		chk(16'(cmds), 16'h0000);
		rstn = 1'b1;
		step(6);
		chk(st & 16'h0078, 16'h0000);
	endtask
	// mode drops first, then a request that must be ignored
	task t_mode;
		jmp = 1'b0;
		step(6);
		ctl = 16'h8100;
		step(6);
		chk(st, 16'h0000);
		chk(16'(cmds), 16'h0000);
	endtask
	initial begin
		step(8);
		rstn = 1'b1;
		step(6);
		t_alive;
		t_peak;
		t_flags;
		t_misc;
		t_reset;
		t_mode;
		summarize;
	end
	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		summarize;
	end
endmodule
